// ### design/tpr_router.sv
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
module tpr_router
   import tpr_pkg::*;
#(
   parameter int NUM_PINS = TPR_NUM_PINS
) (
   input  wire logic                 clk_sys,        // System clock, 100 MHz
   input  wire logic                 reset_n,        // Asynchronous reset, active low
   input  wire tpr_bus_s             bus,            // Register request
   output logic [31:0]               rdata,          // Read data, cycle after the strobe
   input  wire logic [NUM_PINS-1:0]  pin_in,         // Pad input levels
   output logic [NUM_PINS-1:0]       pin_out,        // Pad output levels
   output logic [NUM_PINS-1:0]       pin_oe,         // Pad output enables, high drives
   output logic [NUM_PINS-1:0]       pin_analog_en,  // Pad analog switch enables
   output logic [NUM_PINS-1:0]       pin_open_drain, // Pad is a true open-drain pad
   input  wire logic [NUM_PINS-1:0]  gpio_out,       // GPIO output levels
   input  wire logic [NUM_PINS-1:0]  gpio_oe,        // GPIO output enables
   input  wire logic [TPR_NFUNC-1:0] tmr_out,        // Timer function outputs
   input  wire logic [TPR_NFUNC-1:0] tmr_oe,         // Timer function output enables
   output logic [TPR_NFUNC-1:0]      tmr_in,         // Timer function inputs
   input  wire logic [1:0]           i3c_out,        // Serial clock/data outputs
   input  wire logic [1:0]           i3c_oe,         // Serial clock/data output enables
   output logic [1:0]                i3c_in,         // Serial clock/data inputs
   input  wire logic [TPR_SPC_N-1:0] spc_out,        // Special pin function outputs
   input  wire logic [TPR_SPC_N-1:0] spc_oe,         // Special pin function enables
   output logic [TPR_SPC_N-1:0]      spc_in,         // Special pin function inputs
   output logic                      in_system_programming_mode  // Boot pin was low
);

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Field of function f from the two select registers
   function automatic logic [1:0] fld(input int f, input logic [31:0] s0, input logic [31:0] s1);
      logic [1:0] r;
      if (f < TPR_SEL0_NFLD) begin
         r = s0[2*f +: 2];
      end else begin
         r = s1[2*(f-TPR_SEL0_NFLD) +: 2];
      end
      return r;
   endfunction

   // Pin chosen by a field code, or no pin
   function automatic tpr_pin_t cand(input int f, input logic [1:0] code);
      tpr_pin_t r;
      r = TPR_NO_PIN;
      if (code != TPR_SEL_NC) begin
         r = TPR_CAND[f][code];
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Register state
   logic [31:0]          fixed_pin_function_enable_q;   // Analog enables
   logic [31:0]          fixed_pin_function_enable_d;
   logic [31:0]          timer_pin_select_first_q;      // Sixteen timer fields
   logic [31:0]          timer_pin_select_first_d;
   logic [31:0]          timer_pin_select_second_q;     // Phase input fields
   logic [31:0]          timer_pin_select_second_d;
   logic [31:0]          aux_q;                         // Special enables, serial pins
   logic [31:0]          aux_d;
   logic [31:0]          rdata_d;
   logic                 alive_q;                       // First cycle after release done
   logic                 prog_mode_q;                   // Programming mode latched
   logic                 prog_mode_d;

   // Decode writes and reads; unmapped reads return zero
   always_comb begin
      fixed_pin_function_enable_d = fixed_pin_function_enable_q;
      timer_pin_select_first_d    = timer_pin_select_first_q;
      timer_pin_select_second_d   = timer_pin_select_second_q;
      aux_d                       = aux_q;
      rdata_d                     = '0;
      if (bus.wr) begin
         if (bus.addr == TPR_OFS_FIXED) begin
            fixed_pin_function_enable_d = bus.wdata & TPR_MSK_FIXED;
         end else if (bus.addr == TPR_OFS_SEL0) begin
            timer_pin_select_first_d = bus.wdata;
         end else if (bus.addr == TPR_OFS_SEL1) begin
            timer_pin_select_second_d = bus.wdata & TPR_MSK_SEL1;
         end else if (bus.addr == TPR_OFS_AUX) begin
            aux_d = bus.wdata & TPR_MSK_AUX;
         end
      end
      if (bus.rd) begin
         if (bus.addr == TPR_OFS_FIXED) begin
            rdata_d = fixed_pin_function_enable_q;
         end else if (bus.addr == TPR_OFS_SEL0) begin
            rdata_d = timer_pin_select_first_q;
         end else if (bus.addr == TPR_OFS_SEL1) begin
            rdata_d = timer_pin_select_second_q;
         end else if (bus.addr == TPR_OFS_AUX) begin
            rdata_d = aux_q;
         end else if (bus.addr == TPR_OFS_STAT) begin
            rdata_d = {30'h0, alive_q, prog_mode_q};
         end
      end
   end

   // Boot pin is caught once, on the first edge after release
   always_comb begin
      prog_mode_d = prog_mode_q;
      if (!alive_q) begin
         prog_mode_d = !pin_in[TPR_BOOT_PIN];
      end
   end

   // Registers; special functions and GPIO come up selected
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         fixed_pin_function_enable_q <= TPR_RST_FIXED;
         timer_pin_select_first_q    <= TPR_RST_SEL0;
         timer_pin_select_second_q   <= TPR_RST_SEL1;
         aux_q                       <= TPR_RST_AUX;
         rdata                       <= '0;
         alive_q                     <= 1'b0;
         prog_mode_q                 <= 1'b0;
      end else begin
         fixed_pin_function_enable_q <= fixed_pin_function_enable_d;
         timer_pin_select_first_q    <= timer_pin_select_first_d;
         timer_pin_select_second_q   <= timer_pin_select_second_d;
         aux_q                       <= aux_d;
         rdata                       <= rdata_d;
         alive_q                     <= 1'b1;
         prog_mode_q                 <= prog_mode_d;
      end
   end

   assign in_system_programming_mode = prog_mode_q;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Pin routing
   logic [NUM_PINS-1:0]  pin_out_d;
   logic [NUM_PINS-1:0]  pin_oe_d;
   logic [NUM_PINS-1:0]  ana_d;
   logic [TPR_NFUNC-1:0] tmr_in_d;
   logic [1:0]           i3c_in_d;
   logic [TPR_SPC_N-1:0] spc_in_d;

   // Owners are applied weakest first so the strongest write stands:
   // GPIO, serial bus, timers, special pins, then analog
   always_comb begin
      tpr_pin_t p;
      p         = TPR_NO_PIN;
      pin_out_d = gpio_out;
      pin_oe_d  = gpio_oe;
      ana_d     = '0;
      tmr_in_d  = '0;
      i3c_in_d  = '0;
      spc_in_d  = '0;
      for (int a = 0; a < TPR_ADC_N; a++) begin
         if (fixed_pin_function_enable_q[TPR_ADC_LSB+a]) begin
            ana_d[TPR_ADC_PIN[a]] = 1'b1;
         end
      end
      for (int c = 0; c < TPR_CMP_N; c++) begin
         if (fixed_pin_function_enable_q[TPR_CMP_LSB+c]) begin
            ana_d[TPR_CMP_PIN[c]] = 1'b1;
         end
      end
      // Serial bus pins may land on any pin index
      for (int k = 0; k < 2; k++) begin
         p = aux_q[(k == 0 ? TPR_SCL_LSB : TPR_SDA_LSB) +: 6];
         if (p < NUM_PINS) begin
            pin_out_d[p] = i3c_out[k];
            pin_oe_d[p]  = i3c_oe[k];
            i3c_in_d[k]  = pin_in[p];
         end
      end
      // Descending order lets the lowest function win a shared pin
      for (int f = TPR_NFUNC - 1; f >= 0; f--) begin
         p = cand(f, fld(f, timer_pin_select_first_q, timer_pin_select_second_q));
         if (p < NUM_PINS) begin
            tmr_in_d[f]  = pin_in[p];
            pin_out_d[p] = tmr_out[f];
            pin_oe_d[p]  = tmr_oe[f];
         end
      end
      for (int s = 0; s < TPR_SPC_N; s++) begin
         if (aux_q[s]) begin
            pin_out_d[TPR_SPC_PIN[s]] = spc_out[s];
            pin_oe_d[TPR_SPC_PIN[s]]  = spc_oe[s];
            spc_in_d[s]               = pin_in[TPR_SPC_PIN[s]];
         end
      end
      // Analog pins lose the digital driver entirely
      for (int q = 0; q < NUM_PINS; q++) begin
         if (ana_d[q]) begin
            pin_out_d[q] = 1'b0;
            pin_oe_d[q]  = 1'b0;
         end
      end
   end

   // Pin outputs are registered; nothing drives before the second edge after release
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         pin_out        <= '0;
         pin_oe         <= '0;
         pin_analog_en  <= '0;
         pin_open_drain <= TPR_OD_MASK[NUM_PINS-1:0];
         tmr_in         <= '0;
         i3c_in         <= '0;
         spc_in         <= '0;
      end else begin
         pin_out        <= pin_out_d;
         pin_oe         <= alive_q ? pin_oe_d : '0;
         pin_analog_en  <= ana_d;
         pin_open_drain <= TPR_OD_MASK[NUM_PINS-1:0];
         tmr_in         <= tmr_in_d;
         i3c_in         <= i3c_in_d;
         spc_in         <= spc_in_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   chk_first_sel_write: assert property (
      bus.wr && bus.addr == TPR_OFS_SEL0 |=> timer_pin_select_first_q == $past(bus.wdata))
      else $error("first select register did not take write");
   chk_second_sel_write: assert property (
      bus.wr && bus.addr == TPR_OFS_SEL1
      |=> timer_pin_select_second_q == {28'h0, $past(bus.wdata[3:0])})
      else $error("second select register wrong after write");
   chk_field_nc_open: assert property (
      timer_pin_select_first_q[1:0] inside {2'h2, 2'h3} |=> !tmr_in[0])
      else $error("unconnected timer input not held low");
   chk_field_pick_pin: assert property (
      alive_q && timer_pin_select_first_q[3:2] == 2'h1 |=> tmr_in[1] == $past(pin_in[33]))
      else $error("timer input not taken from selected pin");
   chk_adc_enable_pin: assert property (
      fixed_pin_function_enable_q[TPR_ADC_LSB] |=> pin_analog_en[7] && !pin_oe[7])
      else $error("converter input pin not switched to analog");
   chk_cmp_enable_pin: assert property (
      fixed_pin_function_enable_q[TPR_CMP_LSB+4] |=> pin_analog_en[30])
      else $error("comparator input pin not switched");
   chk_analog_no_drive: assert property (
      pin_analog_en[14] |-> !pin_oe[14] && !pin_out[14])
      else $error("analog pin still driven");
   chk_reset_undriven: assert property (
      !alive_q |=> pin_oe == '0)
      else $error("pin driven right after reset");
   chk_reset_special_on: assert property (
      !alive_q |-> aux_q[2:0] == 3'h7 && fixed_pin_function_enable_q == '0)
      else $error("reset function selection wrong");
   chk_boot_sample: assert property (
      !alive_q |=> prog_mode_q == !$past(pin_in[TPR_BOOT_PIN]) ##1 $stable(prog_mode_q)[*3])
      else $error("boot pin not sampled at release");
   chk_serial_any_pin: assert property (
      aux_q[TPR_SCL_LSB +: 6] < NUM_PINS |=> i3c_in[0] == $past(pin_in[aux_q[13:8]]))
      else $error("serial clock input not routed");

endmodule

// ### design/tpr_pkg.sv
package tpr_pkg;
   ////////////////////////////////////////////////////////////////////////////////////////////
   // Pin space: port 0 pins 0..31, port 1 pins 0..14 at 32..46
   localparam int           TPR_NUM_PINS  = 47;
   localparam logic [5:0]   TPR_NO_PIN    = 6'h3f;   // Marks an absent candidate or no pin
   localparam int           TPR_NFUNC     = 18;      // Timer functions routed by fields
   localparam int           TPR_SEL0_NFLD = 16;      // Fields held in the first select reg
   localparam int           TPR_NCAND     = 3;       // Candidate pins per function
   ////////////////////////////////////////////////////////////////////////////////////////////
   // Register offsets (byte addresses)
   localparam logic [7:0]   TPR_OFS_FIXED = 8'h00;
   localparam logic [7:0]   TPR_OFS_SEL0  = 8'h04;
   localparam logic [7:0]   TPR_OFS_SEL1  = 8'h08;
   localparam logic [7:0]   TPR_OFS_AUX   = 8'h0c;
   localparam logic [7:0]   TPR_OFS_STAT  = 8'h10;
   // Reset values and writable masks
   localparam logic [31:0]  TPR_RST_FIXED = 32'h00000000;
   localparam logic [31:0]  TPR_MSK_FIXED = 32'h00ffffff;
   localparam logic [31:0]  TPR_RST_SEL0  = 32'hffffffff;
   localparam logic [31:0]  TPR_RST_SEL1  = 32'h0000000f;
   localparam logic [31:0]  TPR_MSK_SEL1  = 32'h0000000f;
   localparam logic [31:0]  TPR_RST_AUX   = 32'h003f3f07;
   localparam logic [31:0]  TPR_MSK_AUX   = 32'h003f3f07;
   ////////////////////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int           TPR_CMP_LSB   = 0;
   localparam int           TPR_CMP_N     = 5;
   localparam int           TPR_ADC_LSB   = 12;
   localparam int           TPR_ADC_N     = 12;
   localparam int           TPR_SPC_N     = 3;       // Aux bits 2:0, special pin functions
   localparam int           TPR_SCL_LSB   = 8;       // Aux bits 13:8, serial clock pin
   localparam int           TPR_SDA_LSB   = 16;      // Aux bits 21:16, serial data pin
   localparam logic [1:0]   TPR_SEL_NC    = 2'h3;    // Field code: not connected
   localparam logic [5:0]   TPR_BOOT_PIN  = 6'd12;
   localparam logic [46:0]  TPR_OD_MASK   = 47'h000000000c00;  // Open-drain pins 10, 11
   ////////////////////////////////////////////////////////////////////////////////////////////
   typedef logic [5:0] tpr_pin_t;
   localparam tpr_pin_t TPR_SPC_PIN [TPR_SPC_N] = '{6'd2, 6'd3, 6'd5};
   localparam tpr_pin_t TPR_CMP_PIN [TPR_CMP_N] = '{6'd0, 6'd1, 6'd14, 6'd23, 6'd30};
   localparam tpr_pin_t TPR_ADC_PIN [TPR_ADC_N] = '{6'd7, 6'd6, 6'd14, 6'd23, 6'd22, 6'd21,
                                                    6'd20, 6'd19, 6'd18, 6'd17, 6'd13, 6'd4};
   // Candidate pins per timer function, code 0..2
   localparam tpr_pin_t TPR_CAND [TPR_NFUNC][TPR_NCAND] = '{
      '{6'd24, 6'd30, 6'd63}, '{6'd17, 6'd33, 6'd63}, '{6'd18, 6'd34, 6'd16},
      '{6'd19, 6'd35, 6'd34}, '{6'd20, 6'd36, 6'd27}, '{6'd21, 6'd37, 6'd25},
      '{6'd22, 6'd38, 6'd24}, '{6'd10, 6'd39, 6'd28}, '{6'd11, 6'd44, 6'd35},
      '{6'd13, 6'd45, 6'd63}, '{6'd23, 6'd46, 6'd63}, '{6'd25, 6'd29, 6'd63},
      '{6'd15, 6'd40, 6'd63}, '{6'd16, 6'd41, 6'd63}, '{6'd26, 6'd31, 6'd63},
      '{6'd27, 6'd32, 6'd63}, '{6'd24, 6'd29, 6'd63}, '{6'd25, 6'd30, 6'd63}};
   ////////////////////////////////////////////////////////////////////////////////////////////
   // Register port request
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } tpr_bus_s;
endpackage

// ### dv/tpr_periph_model.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// On-chip peripherals behind the router: GPIO, timers, serial bus, specials
module tpr_periph_model
   import tpr_pkg::*;
(
   input  wire logic                  clk_sys,  // System clock
   input  wire logic                  reset_n,  // Asynchronous reset, active low
   input  wire logic [3:0]            drive,    // Drive enables: spc, i3c, tmr, gpio
   output logic [TPR_NUM_PINS-1:0]    gpio_out, // GPIO levels, low while driving
   output logic [TPR_NUM_PINS-1:0]    gpio_oe,  // GPIO enables
   output logic [TPR_NFUNC-1:0]       tmr_out,  // Timer levels, high while driving
   output logic [TPR_NFUNC-1:0]       tmr_oe,   // Timer enables
   output logic [1:0]                 i3c_out,  // Serial levels, high while driving
   output logic [1:0]                 i3c_oe,   // Serial enables
   output logic [TPR_SPC_N-1:0]       spc_out,  // Special levels, high while driving
   output logic [TPR_SPC_N-1:0]       spc_oe    // Special enables
);
   localparam int W = TPR_SPC_N + 2 + TPR_NFUNC + TPR_NUM_PINS;
   logic [W-1:0] out_q, out_d;  // Output levels of all sources
   logic [W-1:0] en_q, en_d;    // Output enables of all sources
   logic [W-1:0] lvl;           // Level shown while a source drives
   ////////////////////////////////////////////////////////////////////////////////
   // An idle source toggles its level so a router that ignores enables shows it
   always_comb begin
      lvl   = {{TPR_SPC_N{1'b1}}, 2'h3, {TPR_NFUNC{1'b1}}, {TPR_NUM_PINS{1'b0}}};
      en_d  = {{TPR_SPC_N{drive[3]}}, {2{drive[2]}}, {TPR_NFUNC{drive[1]}},
               {TPR_NUM_PINS{drive[0]}}};
      out_d = (lvl & en_d) | (~out_q & ~en_d);
   end
   // Sources come out of reset undriven, like the real peripherals
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         out_q <= '0;
         en_q  <= '0;
      end else begin
         out_q <= out_d;
         en_q  <= en_d;
      end
   end
   assign {spc_out, i3c_out, tmr_out, gpio_out} = out_q;
   assign {spc_oe, i3c_oe, tmr_oe, gpio_oe}     = en_q;
endmodule

// ### dv/testbench.sv
`timescale 1ns/100ps
module testbench;
   import tpr_pkg::*;
   logic                 clk_sys;        // System clock
   logic                 reset_n;        // Reset, active low
   tpr_bus_s             bus;            // Register request
   logic [31:0]          rdata;          // Read data
   logic [46:0]          pin_in;         // Pad levels seen by the router
   logic [46:0]          pin_out;        // Pad output levels
   logic [46:0]          pin_oe;         // Pad output enables
   logic [46:0]          pin_analog_en;  // Pad analog switches
   logic [46:0]          pin_open_drain; // Open-drain pad flags
   logic [46:0]          gpio_out;       // GPIO levels
   logic [46:0]          gpio_oe;        // GPIO enables
   logic [17:0]          tmr_out;        // Timer levels
   logic [17:0]          tmr_oe;         // Timer enables
   logic [17:0]          tmr_in;         // Timer inputs
   logic [1:0]           i3c_out;        // Serial levels
   logic [1:0]           i3c_oe;         // Serial enables
   logic [1:0]           i3c_in;         // Serial inputs
   logic [2:0]           spc_out;        // Special levels
   logic [2:0]           spc_oe;         // Special enables
   logic [2:0]           spc_in;         // Special inputs
   logic                 prog_mode;      // Programming mode flag
   logic [3:0]           tb_drive;       // Peripheral drive knob
   int                   bad_count = 0;  // Mismatches
   int                   n_compared = 0; // Comparisons
   ////////////////////////////////////////////////////////////////////////////////
   tpr_router tpr_router_i (.clk_sys(clk_sys), .reset_n(reset_n), .bus(bus), .rdata(rdata),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_analog_en(pin_analog_en),
      .pin_open_drain(pin_open_drain), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
      .tmr_out(tmr_out), .tmr_oe(tmr_oe), .tmr_in(tmr_in), .i3c_out(i3c_out),
      .i3c_oe(i3c_oe), .i3c_in(i3c_in), .spc_out(spc_out), .spc_oe(spc_oe), .spc_in(spc_in),
      .in_system_programming_mode(prog_mode));
   tpr_periph_model tpr_periph_model_i (.clk_sys(clk_sys), .reset_n(reset_n),
      .drive(tb_drive), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .tmr_out(tmr_out),
      .tmr_oe(tmr_oe), .i3c_out(i3c_out), .i3c_oe(i3c_oe), .spc_out(spc_out),
      .spc_oe(spc_oe));
   ////////////////////////////////////////////////////////////////////////////////
   // Clock at 100 MHz
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // One-cycle strobes, signals changed just after the edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys) bus <= '{a, d, 1'b1, 1'b0};
      @(posedge clk_sys) bus <= '0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk_sys) bus <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge clk_sys) bus <= '0;
      #1 chk_reg(rdata, exp);
   endtask
   // Routing lags its cause by two register stages, three edges is ample
   task automatic settle;
      repeat (3) @(posedge clk_sys);
      #1;
   endtask
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_vec(input logic [46:0] got, input logic [46:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic end_sim;
      $display("compared=%0d mismatches=%0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Watchdog: the tests need under a thousand cycles
   initial begin
      #200000;
      bad_count++;
      end_sim();
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] s0, s1;
      int          p, b;
      bus = '0;
      pin_in = '0;  // Boot pin held low through reset
      tb_drive = 4'h0;
      reset_n = 1'b0;
      repeat (5) @(posedge clk_sys);
      reset_n <= 1'b1;
      settle();
      chk_vec(47'(prog_mode), 47'h1);
      chk_vec(pin_oe | pin_analog_en, '0);
      chk_vec(pin_open_drain, TPR_OD_MASK);
      rd_chk(TPR_OFS_STAT, 32'h00000003);
      rd_chk(TPR_OFS_FIXED, TPR_RST_FIXED);
      rd_chk(TPR_OFS_SEL0, TPR_RST_SEL0);
      rd_chk(TPR_OFS_SEL1, TPR_RST_SEL1);
      rd_chk(TPR_OFS_AUX, TPR_RST_AUX);
      rd_chk(8'h40, 32'h0);
      wr(TPR_OFS_FIXED, 32'hffffffff);
      wr(TPR_OFS_SEL1, 32'hffffffff);
      rd_chk(TPR_OFS_FIXED, 32'h00ffffff);
      rd_chk(TPR_OFS_SEL1, 32'h0000000f);
      wr(TPR_OFS_FIXED, 32'h0);
      // Specials own pins 2, 3 and 5 out of reset, GPIO the rest
      tb_drive <= 4'h9;
      pin_in <= 47'h24;
      settle();
      chk_vec(pin_out, 47'h2c);
      chk_vec(pin_oe, '1);
      chk_vec(47'(spc_in), 47'h5);
      // Every timer function through every field code
      @(posedge clk_sys);
      tb_drive <= 4'h3;
      pin_in <= '1;
      wr(TPR_OFS_AUX, 32'h003f3f00);
      for (int f = 0; f < TPR_NFUNC; f++) begin
         for (int c = 0; c < 4; c++) begin
            s0 = '1;
            s1 = 32'hf;
            if (f < TPR_SEL0_NFLD) s0[2*f +: 2] = 2'(c);
            else s1[2*(f-TPR_SEL0_NFLD) +: 2] = 2'(c);
            wr(TPR_OFS_SEL0, s0);
            wr(TPR_OFS_SEL1, s1);
            settle();
            p = (c < TPR_NCAND) ? int'(TPR_CAND[f][c]) : 63;
            chk_vec(pin_out, (p < 47) ? 47'h1 << p : '0);
            chk_vec(47'(tmr_in), (p < 47) ? 47'h1 << f : '0);
            rd_chk(TPR_OFS_SEL0, s0);
         end
      end
      // Analog beats a timer routed onto the same pin; the timer still hears the pad
      wr(TPR_OFS_SEL0, 32'hfffffffd);
      wr(TPR_OFS_FIXED, 32'h00000010);
      settle();
      chk_vec(pin_out, '0);
      chk_vec(pin_oe, ~(47'h1 << 30));
      chk_vec(47'(tmr_in), 47'h1);
      // Each fixed analog enable takes its own pin off the digital driver
      wr(TPR_OFS_SEL0, '1);
      wr(TPR_OFS_SEL1, 32'hf);
      tb_drive <= 4'h1;
      for (int i = 0; i < TPR_CMP_N + TPR_ADC_N; i++) begin
         b = (i < TPR_CMP_N) ? TPR_CMP_LSB + i : TPR_ADC_LSB + i - TPR_CMP_N;
         p = (i < TPR_CMP_N) ? int'(TPR_CMP_PIN[i]) : int'(TPR_ADC_PIN[i - TPR_CMP_N]);
         wr(TPR_OFS_FIXED, 32'h1 << b);
         settle();
         chk_vec(pin_analog_en, 47'h1 << p);
         chk_vec(pin_oe, ~(47'h1 << p));
      end
      // Serial clock to pin 40, data to pin 31
      wr(TPR_OFS_FIXED, 32'h0);
      tb_drive <= 4'h5;
      pin_in <= 47'h1 << 40;
      wr(TPR_OFS_AUX, 32'h001f2800);
      settle();
      chk_vec(pin_out, (47'h1 << 40) | (47'h1 << 31));
      chk_vec(47'(i3c_in), 47'h1);
      // Second reset with the boot pin high
      @(posedge clk_sys);
      pin_in <= '1;
      reset_n <= 1'b0;
      repeat (5) @(posedge clk_sys);
      chk_vec(pin_oe, '0);
      reset_n <= 1'b1;
      settle();
      chk_vec(47'(prog_mode), 47'h0);
      rd_chk(TPR_OFS_STAT, 32'h00000002);
      rd_chk(TPR_OFS_AUX, TPR_RST_AUX);
      end_sim();
   end
endmodule
